// ===== bench/mpl_link_sink.sv
// far-side model of the serial channels: takes lines, stalls on request
`timescale 1ns/1ps
module mpl_link_sink
	import mpl_pkg::*;
(
	input  wire logic      sys_clk,    // clock
	input  wire logic      resetn,     // synchronous reset, active low
	input  wire logic      stall_en,   // throttle acceptance
	input  wire logic      line_valid, // line offered
	input  wire mpl_line_t line_out,   // line contents
	output logic           line_ready, // line can be taken this cycle
	output logic           acc,        // transfer strobe
	output mpl_line_t      acc_line    // line taken
);
	logic [1:0] gap_q;

	// ==========================================================
	// one accept slot in three, so the sender must hold a line
	always_ff @(posedge sys_clk) begin
		if (!resetn)
			gap_q <= 2'h0;
		else
			gap_q <= (gap_q == 2'h2) ? 2'h0 : gap_q + 2'h1;
	end
	assign line_ready = !stall_en || (gap_q == 2'h0);
	assign acc        = line_valid && line_ready;
	assign acc_line   = line_out;
endmodule : mpl_link_sink

// ===== bench/mpl_sequencer_assertions.sv
// port assertions for the pattern load sequencer
`timescale 1ns/1ps
module mpl_seq_chk
	import mpl_pkg::*;
(
	input wire logic      sys_clk,           // clock
	input wire logic      resetn,            // synchronous reset, active low
	input wire logic      avs_read,          // read request
	input wire logic      avs_write,         // write request
	input wire logic      avs_waitrequest,   // stall
	input wire logic      avs_response_err,  // unmapped access
	input wire logic      init_done,         // registers ready
	input wire logic      line_ready,        // far side accepts
	input wire logic      line_valid,        // line offered
	input wire mpl_line_t line_out,          // line contents
	input wire logic      mirror_reset_start // reset start pulse
);
	// ==========================================================
	// one clock domain; reset aborts every attempt
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	err_answer_a: assert property (avs_response_err |-> (avs_read || avs_write) && !avs_waitrequest)
		else $error("error flag outside answer");
	init_rise_a: assert property (resetn |=> init_done)
		else $error("init done missing");
	hold_line_a: assert property (line_valid && !line_ready |=> line_valid && $stable(line_out))
		else $error("line changed while stalled");
	nodata_load_a: assert property (line_valid && !line_out.cmd_valid |-> line_out.array_load)
		else $error("dataless line without load");
	dbl_rows_a: assert property (line_valid && line_out.double_row_load |-> line_out.row < 8'h44)
		else $error("double row line index too high");
	row_range_a: assert property (line_valid |-> line_out.row < 8'h88)
		else $error("row outside block");
	pulse_once_a: assert property (mirror_reset_start |=> !mirror_reset_start)
		else $error("reset start longer than one cycle");
	slow_wait_a: assert property (line_valid && line_ready && line_out.slow_channel && line_out.array_load
		&& line_out.segment != 2'h0 |=> !mirror_reset_start [*2])
		else $error("reset start before last segment");
endmodule : mpl_seq_chk

bind mpl_sequencer mpl_seq_chk u_chk (.sys_clk(sys_clk), .resetn(resetn), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err),
	.init_done(init_done), .line_ready(line_ready), .line_valid(line_valid), .line_out(line_out),
	.mirror_reset_start(mirror_reset_start));

// ===== bench/tb.sv
// self-checking bench for the pattern load sequencer
`timescale 1ns/1ps
module tb
	import mpl_pkg::*;
;
	logic sys_clk, resetn, avs_read, avs_write, stall_en, got0, rerr;
	logic [3:0] avs_address, avs_byteenable, pk;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic avs_waitrequest, avs_response_err, init_done, line_ready, line_valid, mirror_reset_start, acc;
	mpl_line_t line_out, acc_line;
	int num_errors, comparisons, lines, pulses, loads, cmds;
	logic [15:0] blk_seen;
	logic [7:0] seg_seq, segs;
	logic [ARRAY_COLS-1:0] px, row0, r0s, r0a;

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// hold longer than one single-block frame, so cycling shows every pattern once per frame
	mpl_sequencer #(.CYCLE_HOLD(400)) DUT (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.avs_response_err(avs_response_err), .init_done(init_done), .line_ready(line_ready),
		.line_valid(line_valid), .line_out(line_out), .mirror_reset_start(mirror_reset_start));
	mpl_link_sink u_sink (.sys_clk(sys_clk), .resetn(resetn), .stall_en(stall_en), .line_valid(line_valid),
		.line_out(line_out), .line_ready(line_ready), .acc(acc), .acc_line(acc_line));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic end_sim();
		if (num_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	// ==========================================================
	// monitor: values sampled mid-cycle are those taken at the next edge
	assign px = acc_line.pixels;
	always @(negedge sys_clk) begin
		if (mirror_reset_start) pulses++;
		if (acc) begin
			if (lines == 0 || acc_line.segment != seg_seq[1:0]) seg_seq = {seg_seq[5:0], acc_line.segment};
			lines++;
			blk_seen[acc_line.block] = 1'b1;
			loads += int'(acc_line.array_load);
			cmds += int'(acc_line.cmd_valid);
			if (acc_line.row == 8'h0 && !got0) row0 = px;
			if (acc_line.row == 8'h0) got0 = 1'b1;
			if (pk == 4'h1) chk(32'(px === '1), 32'h1);
			if (pk == 4'h2) chk(32'(px === '0), 32'h1);
			if (pk == 4'h3) chk(32'(px === {128{2'b10}} || px === {128{2'b01}}), 32'h1);
			if (pk == 4'h4) chk(32'((px[31:0] === '0 || px[31:0] === '1) && px[32] !== px[31]), 32'h1);
		end
	end

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		int k;
		logic w;
		@(posedge sys_clk);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		k = 0;
		do begin
			@(negedge sys_clk);
			w = avs_waitrequest;
			rd = avs_readdata;
			rerr = avs_response_err;
			@(posedge sys_clk);
			k++;
		end while (w && k < 100);
		chk({31'h0, w}, 32'h0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic run(input mpl_mode_t md, input mpl_pattern_t pat, input logic [15:0] msk, input logic fl,
		input int rows, input logic [3:0] kind);
		int k;
		int nb;
		nb = $countones(msk);
		bus(1'b1, REG_PATTERN, {28'h0, pat}, 4'hF);
		bus(1'b1, REG_BLOCK_MASK, {16'h0, msk}, 4'hF);
		{lines, pulses, loads, cmds} = '0;
		{blk_seen, seg_seq, got0} = '0;
		pk = kind;
		bus(1'b1, REG_CTRL, 32'h1 | (32'(fl) << 2) | (32'(md) << 4), 4'hF);
		k = 0;
		while (pulses < ((md == MODE_SINGLE || md == MODE_SLOW) ? nb : 1) && k < 20000) begin
			@(posedge sys_clk);
			k++;
		end
		chk(32'(k < 20000), 32'h1);
		if (rows != 0) chk(32'(lines), 32'(rows * nb));
		chk({16'h0, blk_seen}, {16'h0, msk});
		chk(32'(loads), 32'((md == MODE_SLOW ? 4 : 1) * nb));
		chk(32'(cmds), (md == MODE_CLEAR || md == MODE_SET) ? 32'h0 : 32'(lines));
		segs = seg_seq;
		r0s = row0;
		pk = 4'h0;
		bus(1'b1, REG_CTRL, 32'h0, 4'hF);
		repeat (3000) @(posedge sys_clk);
		{lines, pulses} = '0;
		repeat (300) @(posedge sys_clk);
		chk(32'(lines + pulses), 32'h0);
	endtask : run

	task automatic t_regs();
		bus(1'b0, REG_CTRL, 32'h0, 4'h0);
		chk(rd, CTRL_RESET);
		bus(1'b0, REG_PATTERN, 32'h0, 4'h0);
		chk(rd, {28'h0, PAT_RESET});
		bus(1'b1, REG_BLOCK_MASK, 32'h0000_1234, 4'h2);
		bus(1'b0, REG_BLOCK_MASK, 32'h0, 4'h0);
		chk(rd, {16'h0, 8'h12, MASK_RESET[7:0]});
		bus(1'b0, REG_STATUS, 32'h0, 4'h0);
		chk(rd & 32'h1, 32'h1);
		bus(1'b1, 4'h6, 32'hFFFF_FFFF, 4'hF);
		chk({31'h0, rerr}, 32'h1);
		bus(1'b0, 4'h2, 32'h0, 4'h0);
		chk(rd, 32'h0);
		chk({31'h0, rerr}, 32'h1);
	endtask : t_regs

	task automatic t_images();
		run(MODE_GLOBAL, PAT_FINE_H, 16'h0001, 1'b0, 136, 4'h0);
		r0a = r0s;
		chk(32'(r0a === '0 || r0a === '1), 32'h1);
		run(MODE_GLOBAL, PAT_FINE_H, 16'h0001, 1'b1, 136, 4'h0);
		chk(32'(r0s === ~r0a), 32'h1);
		run(MODE_GLOBAL, PAT_CHECKER, 16'h0001, 1'b0, 136, 4'h0);
		r0a = r0s;
		chk(32'((r0a[63:0] === '0 || r0a[63:0] === '1) && r0a[64] !== r0a[63]), 32'h1);
		run(MODE_GLOBAL, PAT_CHECKER_INV, 16'h0001, 1'b0, 136, 4'h0);
		chk(32'(r0s === ~r0a), 32'h1);
		run(MODE_GLOBAL, PAT_BORDER_GRID, 16'h0001, 1'b0, 136, 4'h0);
		chk(32'(r0s === '1), 32'h1);
	endtask : t_images

	task automatic t_cycle();
		int j;
		int n;
		bus(1'b1, REG_PATTERN, 32'h0, 4'hF);
		bus(1'b1, REG_CTRL, 32'h3, 4'hF);
		for (j = 1; j <= CYCLE_PAT_COUNT; j++) begin
			n = 0;
			do begin
				bus(1'b0, REG_STATUS, 32'h0, 4'h0);
				n++;
			end while (rd[5:2] !== 4'(j % CYCLE_PAT_COUNT) && n < 400);
			chk({28'h0, rd[5:2]}, 32'(j % CYCLE_PAT_COUNT));
		end
		bus(1'b1, REG_CTRL, 32'h0, 4'hF);
	endtask : t_cycle

	initial begin
		{avs_read, avs_write, stall_en, resetn} = '0;
		{avs_address, avs_byteenable, avs_writedata, pk} = '0;
		{num_errors, comparisons, lines, pulses, loads, cmds} = '0;
		repeat (16) @(posedge sys_clk);
		resetn <= 1'b1;
		stall_en <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk({31'h0, init_done}, 32'h1);
		t_regs();
		run(MODE_GLOBAL, PAT_ALL_ON, 16'h8001, 1'b0, 136, 4'h1);
		run(MODE_SINGLE, PAT_ALL_OFF, 16'h0006, 1'b0, 136, 4'h2);
		run(MODE_CLEAR, PAT_ALL_ON, 16'h0003, 1'b0, 1, 4'h2);
		run(MODE_SET, PAT_ALL_OFF, 16'h0003, 1'b0, 1, 4'h1);
		run(MODE_DOUBLE_ROW, PAT_CHECKER2, 16'h0001, 1'b0, 68, 4'h4);
		run(MODE_SLOW, PAT_ALL_ON, 16'h0001, 1'b0, 0, 4'h1);
		chk({24'h0, segs}, 32'h0000_00E4);
		stall_en <= 1'b0;
		run(MODE_GLOBAL, PAT_FINE_V, 16'h0001, 1'b0, 136, 4'h3);
		t_images();
		t_cycle();
		end_sim();
	end

	// watchdog: all scenarios together need well under this many cycles
	initial begin
		repeat (95000) @(posedge sys_clk);
		num_errors++;
		end_sim();
	end
endmodule : tb

// ===== design/mpl_pkg.sv
// package of constants, types and register map for the mirror pattern load sequencer
package mpl_pkg;

	// ==========================================================
	// clock and timing
	localparam int          SYS_CLK_HZ        = 20_000_000;
	localparam int          CYCLE_HOLD_S      = 2;
	localparam int          CYCLE_HOLD_CYC    = SYS_CLK_HZ * CYCLE_HOLD_S;
	localparam int          CYCLE_PAT_COUNT   = 8;

	// ==========================================================
	// array geometry
	localparam int          ARRAY_COLS        = 256;
	localparam int          ARRAY_ROWS        = 136;
	localparam int          BLOCK_COUNT       = 16;
	localparam int          SEG_COUNT         = 4;
	localparam int          ROWS_PER_BLOCK    = ARRAY_ROWS;
	localparam int          DOUBLE_ROW_MAX    = 68;
	localparam int          CHECKER_SIZE      = 64;
	localparam int          CHECKER2_SIZE     = 32;
	localparam int          DOT_PITCH         = 10;
	localparam int          LANES_FAST        = 12;
	localparam int          LANES_SLOW        = 4;
	localparam logic [1:0]  SEG_FIRST         = 2'h3;

	// ==========================================================
	// register map, byte addresses on the avalon bus
	localparam logic [3:0]  REG_CTRL          = 4'h0;
	localparam logic [3:0]  REG_PATTERN       = 4'h4;
	localparam logic [3:0]  REG_BLOCK_MASK    = 4'h8;
	localparam logic [3:0]  REG_STATUS        = 4'hC;

	// control field positions
	localparam int          CTRL_GEN_EN_BIT   = 0;
	localparam int          CTRL_CYCLE_BIT    = 1;
	localparam int          CTRL_FLIP_BIT     = 2;
	localparam int          CTRL_MODE_LSB     = 4;
	localparam int          PAT_SEL_LSB       = 0;

	// reset values
	localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
	localparam logic [3:0]  PAT_RESET         = 4'h0;
	localparam logic [15:0] MASK_RESET        = 16'hFFFF;

	// ==========================================================
	// enumerations
	typedef enum logic [3:0] {
		PAT_ALL_ON, PAT_ALL_OFF, PAT_CHECKER, PAT_BORDER_GRID,
		PAT_DIAG_WE, PAT_DIAG_EW, PAT_HLINES, PAT_VLINES,
		PAT_CHECKER2, PAT_DOTS, PAT_CHECKER_INV, PAT_NOISE,
		PAT_FINE_H, PAT_FINE_V, PAT_ON_OFF
	} mpl_pattern_t;

	typedef enum logic [2:0] {
		MODE_GLOBAL, MODE_SINGLE, MODE_CLEAR, MODE_SET,
		MODE_DOUBLE_ROW, MODE_SLOW
	} mpl_mode_t;

	// latched configuration for one pattern load
	typedef struct packed {
		logic         cycle_en;
		logic         flip;
		mpl_mode_t    mode;
		mpl_pattern_t pattern;
		logic [15:0]  mask;
	} mpl_cfg_t;

	// one line handed to the serial channels
	typedef struct packed {
		logic                  cmd_valid;
		logic                  array_load;
		logic                  double_row_load;
		logic                  slow_channel;
		logic [1:0]            segment;
		logic [3:0]            block;
		logic [7:0]            row;
		logic [ARRAY_COLS-1:0] pixels;
	} mpl_line_t;

endpackage : mpl_pkg

// ===== design/mpl_row_mem.sv
// small row store holding the last generated line of each of the four segments; its read data is left unconnected in the sequencer
`timescale 1ns/1ps
module mpl_row_mem
	import mpl_pkg::*;
(
	input  wire logic                  sys_clk,   // system clock
	input  wire logic                  wr_en,     // write strobe
	input  wire logic [1:0]            wr_addr,   // write slot
	input  wire logic [ARRAY_COLS-1:0] wr_data,   // line to store
	input  wire logic [1:0]            rd_addr,   // read slot
	output logic      [ARRAY_COLS-1:0] rd_data    // registered read data
);

	logic [ARRAY_COLS-1:0] mem [SEG_COUNT];

	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule : mpl_row_mem

// ===== design/mpl_sequencer.sv
// test pattern source and block load sequencer with avalon register slave
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - pattern generator enable gates the start of each frame; a frame already started is sent to its end
// - cycling steps through first eight patterns, two seconds each
// - without cycling only the selected pattern is sent
// - north/south flip reverses row order of the image
// - all-on drives every mirror on, all-off every mirror off
// - checkerboard squares are 64 by 64 pixels
// - double-row checkerboard squares are 32 by 32 pixels
// - dots: single white pixel every 10 pixels both ways
// - inverting checkerboard is complement of standard checkerboard
// - fine lines alternate every row, or every column
// - on/off toggle alternates all-on and all-off
// - border grid lights the array's outer pixels
// - clear mode: load signal only, no data, mirrors go 0
// - set mode: load signal only, no data, mirrors go 1
// - global modes: one reset start after all enabled blocks loaded
// - double-row: each line fills two rows, at most 68 lines per block
// - double-row halves load time, reset timing unchanged
// - slow mode uses one four-lane channel, segments sequential
// - slow mode segment order 3, 2, 1, then 0
// - slow mode resets only after all four segments sent
// - single phased mode: load one block then reset that block
// - sixteen blocks; active mask selects blocks loaded and reset
// - registers read and written by separate operations per register
module mpl_sequencer
	import mpl_pkg::*;
#(
	parameter int CYCLE_HOLD = CYCLE_HOLD_CYC
) (
	input  wire logic        sys_clk,          // 20 MHz clock
	input  wire logic        resetn,           // synchronous reset, active low
	input  wire logic [3:0]  avs_address,      // byte address
	input  wire logic        avs_read,         // read request
	input  wire logic        avs_write,        // write request
	input  wire logic [31:0] avs_writedata,    // write data
	input  wire logic [3:0]  avs_byteenable,   // byte lanes
	output logic      [31:0] avs_readdata,     // read data
	output logic             avs_waitrequest,  // stall
	output logic             avs_response_err, // unmapped access
	output logic             init_done,        // registers ready
	input  wire logic        line_ready,       // serial channels accept a line
	output logic             line_valid,       // line offered
	output mpl_line_t        line_out,         // line contents
	output logic             mirror_reset_start // one-cycle reset start pulse
);

	// ==========================================================
	// register slave
	logic [31:0] ctrl_q;
	logic [3:0]  pat_sel_q;
	logic [15:0] mask_q;
	logic        ack_q;
	logic        init_q;
	logic        busy;
	logic [3:0]  cur_pat;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
		end
		return r;
	endfunction : merge

	// one wait cycle so read data come from a register
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign init_done       = init_q;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			init_q <= 1'b0;
		end else begin
			init_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end

	// writes land on the acknowledging edge, one operation per register
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			ctrl_q    <= CTRL_RESET;
			pat_sel_q <= PAT_RESET;
			mask_q    <= MASK_RESET;
		end else if (avs_write && ack_q) begin
			unique case (avs_address)
				REG_CTRL:       ctrl_q    <= merge(ctrl_q, avs_writedata, avs_byteenable);
				REG_PATTERN:    pat_sel_q <= 4'(merge({28'h0, pat_sel_q}, avs_writedata, avs_byteenable));
				REG_BLOCK_MASK: mask_q    <= 16'(merge({16'h0, mask_q}, avs_writedata, avs_byteenable));
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			avs_readdata     <= 32'h0000_0000;
			avs_response_err <= 1'b0;
		end else begin
			avs_response_err <= 1'b0;
			if (avs_read && !ack_q) begin
				unique case (avs_address)
					REG_CTRL:       avs_readdata <= {25'h0, ctrl_q[6:4], 1'b0, ctrl_q[2:0]};
					REG_PATTERN:    avs_readdata <= {28'h0, pat_sel_q};
					REG_BLOCK_MASK: avs_readdata <= {16'h0, mask_q};
					REG_STATUS:     avs_readdata <= {26'h0, cur_pat, busy, init_q};
					default: begin
						avs_readdata     <= 32'h0000_0000;
						avs_response_err <= 1'b1;
					end
				endcase
			end else if ((avs_read || avs_write) && !ack_q) begin
				avs_response_err <= !(avs_address inside {REG_CTRL, REG_PATTERN, REG_BLOCK_MASK, REG_STATUS});
			end
		end
	end

	// ==========================================================
	// pattern cycling timer
	logic [31:0] hold_cnt_q;
	logic [2:0]  cyc_idx_q;
	logic        toggle_q;

	// a two second hold, then step
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			hold_cnt_q <= 32'h0000_0000;
			cyc_idx_q  <= 3'h0;
			toggle_q   <= 1'b0;
		end else if (!ctrl_q[CTRL_GEN_EN_BIT]) begin
			hold_cnt_q <= 32'h0000_0000;
			cyc_idx_q  <= 3'h0;
		end else if (hold_cnt_q == 32'(CYCLE_HOLD - 1)) begin
			hold_cnt_q <= 32'h0000_0000;
			toggle_q   <= ~toggle_q;
			if (ctrl_q[CTRL_CYCLE_BIT]) begin
				cyc_idx_q <= cyc_idx_q + 3'h1;
			end
		end else begin
			hold_cnt_q <= hold_cnt_q + 32'h1;
		end
	end

	// ==========================================================
	// load sequencer
	typedef enum logic [2:0] {ST_IDLE, ST_LINE, ST_NEXT, ST_RESET} mpl_state_t;

	mpl_state_t  state_q;
	mpl_cfg_t    cfg_q;
	logic [3:0]  blk_q;
	logic [1:0]  seg_q;
	logic [7:0]  row_q;
	logic [7:0]  last_row;
	logic        blk_last;
	logic [ARRAY_COLS-1:0] pix;
	logic [3:0]  next_blk;
	logic        has_next;
	logic        no_data;

	assign busy    = (state_q != ST_IDLE);
	assign cur_pat = cfg_q.pattern;
	assign no_data = (cfg_q.mode == MODE_CLEAR) || (cfg_q.mode == MODE_SET);

	// double-row sends half the lines per block
	assign last_row = (cfg_q.mode == MODE_DOUBLE_ROW) ? 8'(DOUBLE_ROW_MAX - 1) : 8'(ROWS_PER_BLOCK - 1);

	// next enabled block after blk_q
	always_comb begin
		next_blk = blk_q;
		has_next = 1'b0;
		for (int i = BLOCK_COUNT - 1; i >= 0; i--) begin
			if (i > int'(blk_q) && cfg_q.mask[i]) begin
				next_blk = 4'(i);
				has_next = 1'b1;
			end
		end
	end

	function automatic logic [3:0] first_blk(input logic [15:0] m);
		logic [3:0] r;
		r = 4'h0;
		for (int i = BLOCK_COUNT - 1; i >= 0; i--) begin
			if (m[i]) r = 4'(i);
		end
		return r;
	endfunction : first_blk

	// pixel of one column on one array row
	function automatic logic pixel(input mpl_pattern_t p, input int x, input int y, input logic tog, input int noise);
		logic chk;
		chk = ((x / CHECKER_SIZE) + (y / CHECKER_SIZE)) % 2 == 1;
		unique case (p)
			PAT_ALL_ON:      return 1'b1;
			PAT_ALL_OFF:     return 1'b0;
			PAT_CHECKER:     return chk;
			PAT_CHECKER_INV: return ~chk;
			PAT_CHECKER2:    return ((x / CHECKER2_SIZE) + (y / CHECKER2_SIZE)) % 2 == 1;
			PAT_DOTS:        return (x % DOT_PITCH == 0) && (y % DOT_PITCH == 0);
			PAT_BORDER_GRID: return x == 0 || y == 0 || x == ARRAY_COLS - 1 || y == ARRAY_ROWS - 1;
			PAT_DIAG_WE:     return (x % 16) == (y % 16);
			PAT_DIAG_EW:     return (x % 16) == (15 - (y % 16));
			PAT_HLINES:      return (y % 16) < 8;
			PAT_VLINES:      return (x % 16) < 8;
			PAT_FINE_H:      return y % 2 == 1;
			PAT_FINE_V:      return x % 2 == 1;
			PAT_ON_OFF:      return tog;
			PAT_NOISE:       return ((x * 37 + y * 91 + noise) % 7) < 3;
			default:         return 1'b0;
		endcase
	endfunction : pixel

	// the whole line is generated combinationally; flip reverses the row index
	always_comb begin
		int y;
		y = (cfg_q.mode == MODE_DOUBLE_ROW) ? 2 * int'(row_q) : int'(row_q);
		if (cfg_q.flip) y = ARRAY_ROWS - 1 - y;
		pix = '0;
		for (int x = 0; x < ARRAY_COLS; x++) begin
			pix[x] = pixel(cfg_q.pattern, x, y, toggle_q, int'(blk_q));
		end
	end

	mpl_line_t line_q;
	logic      rst_pulse_q;

	assign line_out           = line_q;
	assign mirror_reset_start = rst_pulse_q;
	assign blk_last           = (row_q == last_row) || no_data;

	mpl_row_mem u_row_mem (
		.sys_clk (sys_clk),
		.wr_en   (state_q == ST_LINE && line_ready),
		.wr_addr (seg_q),
		.wr_data (pix),
		.rd_addr (seg_q),
		.rd_data ()
	);

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_q     <= ST_IDLE;
			cfg_q       <= '0;
			blk_q       <= 4'h0;
			seg_q       <= SEG_FIRST;
			row_q       <= 8'h00;
			line_valid  <= 1'b0;
			line_q      <= '0;
			rst_pulse_q <= 1'b0;
		end else begin
			rst_pulse_q <= 1'b0;
			unique case (state_q)
				ST_IDLE: begin
					// settings are latched only here, never mid-block
					if (ctrl_q[CTRL_GEN_EN_BIT] && mask_q != 16'h0) begin
						cfg_q.cycle_en <= ctrl_q[CTRL_CYCLE_BIT];
						cfg_q.flip     <= ctrl_q[CTRL_FLIP_BIT];
						cfg_q.mode     <= mpl_mode_t'(ctrl_q[CTRL_MODE_LSB +: 3]);
						cfg_q.pattern  <= ctrl_q[CTRL_CYCLE_BIT] ? mpl_pattern_t'({1'b0, cyc_idx_q})
						                                         : mpl_pattern_t'(pat_sel_q);
						cfg_q.mask     <= mask_q;
						blk_q          <= first_blk(mask_q);
						seg_q          <= SEG_FIRST;
						row_q          <= 8'h00;
						state_q        <= ST_LINE;
					end
				end
				ST_LINE: begin
					line_valid <= 1'b1;
					// the offered line is frozen until taken: a toggling pattern must not change it mid-stall
					if (!line_valid) begin
						line_q.cmd_valid       <= ~no_data;
						line_q.array_load      <= blk_last;
						line_q.double_row_load <= (cfg_q.mode == MODE_DOUBLE_ROW);
						line_q.slow_channel    <= (cfg_q.mode == MODE_SLOW);
						line_q.segment         <= seg_q;
						line_q.block           <= blk_q;
						line_q.row             <= row_q;
						line_q.pixels          <= no_data ? {ARRAY_COLS{cfg_q.mode == MODE_SET}} : pix;
					end
					if (line_valid && line_ready) begin
						line_valid <= 1'b0;
						if (blk_last) begin
							row_q <= 8'h00;
							if (cfg_q.mode == MODE_SLOW && seg_q != 2'h0) begin
								seg_q   <= seg_q - 2'h1;
							end else begin
								seg_q   <= SEG_FIRST;
								state_q <= ST_NEXT;
							end
						end else begin
							row_q <= row_q + 8'h01;
						end
					end
				end
				ST_NEXT: begin
					// phased modes reset each block; global ones after the last
					rst_pulse_q <= (cfg_q.mode == MODE_SINGLE || cfg_q.mode == MODE_SLOW) || !has_next;
					if (has_next) begin
						blk_q   <= next_blk;
						state_q <= ST_LINE;
					end else begin
						state_q <= ST_RESET;
					end
				end
				ST_RESET: begin
					// wait for the next hold interval whenever the generator stays enabled
					if (!ctrl_q[CTRL_GEN_EN_BIT] || hold_cnt_q == 32'h0) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

endmodule : mpl_sequencer
